// [lpddr_defines.svh]
// timing counts, widths and the auto-precharge bit for the bank state legality block
`ifndef LPDDR_DEFINES_SVH
`define LPDDR_DEFINES_SVH
`define CLK_PERIOD_NS 8
`define T_RP_NS 18
`define T_RCD_NS 18
`define T_WR_NS 12
`define T_RFC_NS 80
`define T_MRD_NS 16
`define T_PDEX_NS 8
`define T_SRX_NS 120
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC `CYC_UP(`T_RP_NS)
`define RCD_CYC `CYC_UP(`T_RCD_NS)
`define WR_CYC `CYC_UP(`T_WR_NS)
`define RFC_CYC `CYC_UP(`T_RFC_NS)
`define MRD_CYC `CYC_UP(`T_MRD_NS)
`define PDEX_CYC `CYC_UP(`T_PDEX_NS)
`define SRX_CYC `CYC_UP(`T_SRX_NS)
`define CNT_W 5
`define NUM_BANKS 4
`define AP_BIT 10
`endif

// [lpddr_pkg.sv]
// types shared by the bank state legality block
package lpddr_pkg;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_BST = 4'h1,
    CMD_RD = 4'h2,
    CMD_WR = 4'h3,
    CMD_ACT = 4'h4,
    CMD_PRE = 4'h5,
    CMD_REF = 4'h6,
    CMD_MRS = 4'h7,
    CMD_DESEL = 4'h8
  } cmd_e;
  typedef enum logic [5:0] {
    BK_IDLE = 6'h01,
    BK_ACTIVATING = 6'h02,
    BK_ACTIVE = 6'h04,
    BK_PRECHARGING = 6'h08,
    BK_WRITE_REC = 6'h10,
    BK_BUSY = 6'h20
  } bank_e;
  typedef enum logic [3:0] {
    PW_NORMAL = 4'h1,
    PW_SELF_REF = 4'h2,
    PW_POWER_DOWN = 4'h4,
    PW_WAKE = 4'h8
  } power_e;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [12:0] addr;
  } cmd_pins_s;
  typedef struct packed {
    logic accepted;
    logic illegal;
    logic nop;
  } verdict_s;
endpackage

// [lpddr_bank_state_cmd_legality.sv]
// command legality, bank state and power state tracking for a low-power ddr die
`include "lpddr_defines.svh"
module lpddr_bank_state_cmd_legality (
  input wire logic ref_clk, // 125 MHz device clock
  input wire logic rst, // synchronous, active high
  input wire logic cke, // clock enable pin
  input wire lpddr_pkg::cmd_pins_s cmd_pins, // command, bank and address pins
  input wire logic wr_autopre, // write carries auto precharge
  output logic cmd_accepted_ff, // command taken by addressed bank, by every bank on refresh or mode set, or by every active bank on precharge all
  output logic cmd_illegal_ff, // command illegal in current state
  output logic cmd_nop_ff, // command treated as no operation
  output logic self_refresh_ff, // device is in self-refresh
  output logic power_down_ff, // device is in power-down
  output logic all_idle_ff, // all banks idle
  output logic [23:0] bank_state_ff // per bank one-hot state, bank 0 low
);
  localparam int NB = `NUM_BANKS;
  localparam logic [`CNT_W-1:0] RP_C = `CNT_W'(`RP_CYC);
  localparam logic [`CNT_W-1:0] RCD_C = `CNT_W'(`RCD_CYC);
  localparam logic [`CNT_W-1:0] WR_C = `CNT_W'(`WR_CYC);
  localparam logic [`CNT_W-1:0] RFC_C = `CNT_W'(`RFC_CYC);
  localparam logic [`CNT_W-1:0] MRD_C = `CNT_W'(`MRD_CYC);
  localparam logic [`CNT_W-1:0] PDEX_C = `CNT_W'(`PDEX_CYC);
  localparam logic [`CNT_W-1:0] SRX_C = `CNT_W'(`SRX_CYC);

  function automatic lpddr_pkg::cmd_e decode(input lpddr_pkg::cmd_pins_s p);
    if (p.cs_n)
    begin
      return lpddr_pkg::CMD_DESEL;
    end
    case ({p.ras_n, p.cas_n, p.we_n})
      3'h7: return lpddr_pkg::CMD_NOP;
      3'h6: return lpddr_pkg::CMD_BST;
      3'h5: return lpddr_pkg::CMD_RD;
      3'h4: return lpddr_pkg::CMD_WR;
      3'h3: return lpddr_pkg::CMD_ACT;
      3'h2: return lpddr_pkg::CMD_PRE;
      3'h1: return lpddr_pkg::CMD_REF;
      default: return lpddr_pkg::CMD_MRS;
    endcase
  endfunction

  logic cke_prev_ff;
  logic nxt_cke_prev;
  lpddr_pkg::power_e pwr_ff;
  lpddr_pkg::power_e nxt_pwr;
  logic [`CNT_W-1:0] wake_cnt_ff;
  logic [`CNT_W-1:0] nxt_wake_cnt;
  lpddr_pkg::bank_e bank_ff [NB];
  lpddr_pkg::bank_e nxt_bank [NB];
  logic [`CNT_W-1:0] bcnt_ff [NB];
  logic [`CNT_W-1:0] nxt_bcnt [NB];
  logic apre_ff [NB];
  logic nxt_apre [NB];
  logic nxt_accepted;
  logic nxt_illegal;
  logic nxt_nop;
  lpddr_pkg::cmd_e cmd;
  logic cmd_window;
  logic idle_now;
  lpddr_pkg::bank_e sel_state;
  logic [NB-1:0] idle_vec;

  assign cmd = decode(cmd_pins);
  // normal table only with enable held high and device awake
  assign cmd_window = cke_prev_ff && cke && (pwr_ff == lpddr_pkg::PW_NORMAL);
  assign sel_state = bank_ff[cmd_pins.bank];

  generate
    for (genvar g = 0; g < NB; g++)
    begin : g_idle
      assign idle_vec[g] = (bank_ff[g] == lpddr_pkg::BK_IDLE);
    end
  endgenerate
  assign idle_now = &idle_vec;

  // power state: enable history decides, command pins ignored while asleep
  always_comb
  begin
    nxt_cke_prev = cke;
    nxt_pwr = pwr_ff;
    nxt_wake_cnt = wake_cnt_ff;
    case (pwr_ff)
      lpddr_pkg::PW_NORMAL:
      begin
        if (cke_prev_ff && !cke && idle_now)
        begin
          if (cmd == lpddr_pkg::CMD_REF)
            nxt_pwr = lpddr_pkg::PW_SELF_REF;
          else if (cmd == lpddr_pkg::CMD_DESEL || cmd == lpddr_pkg::CMD_NOP)
            nxt_pwr = lpddr_pkg::PW_POWER_DOWN;
        end
      end
      lpddr_pkg::PW_SELF_REF:
      begin
        // exit only on low-high; inputs reawaken, then setup before commands
        if (!cke_prev_ff && cke)
        begin
          nxt_pwr = lpddr_pkg::PW_WAKE;
          nxt_wake_cnt = SRX_C;
        end
      end
      lpddr_pkg::PW_POWER_DOWN:
      begin
        if (!cke_prev_ff && cke)
        begin
          nxt_pwr = lpddr_pkg::PW_WAKE;
          nxt_wake_cnt = PDEX_C;
        end
      end
      lpddr_pkg::PW_WAKE:
      begin
        if (wake_cnt_ff <= `CNT_W'(1))
          nxt_pwr = lpddr_pkg::PW_NORMAL;
        nxt_wake_cnt = wake_cnt_ff - `CNT_W'(1);
      end
      default: nxt_pwr = lpddr_pkg::PW_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cke_prev_ff <= 1'b0;
      pwr_ff <= lpddr_pkg::PW_NORMAL;
      wake_cnt_ff <= '0;
    end
    else
    begin
      cke_prev_ff <= nxt_cke_prev;
      pwr_ff <= nxt_pwr;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end

  // bank states and verdict; the addressed bank is judged, except refresh, mode set and precharge all, which look at every bank
  always_comb
  begin
    nxt_accepted = 1'b0;
    nxt_illegal = 1'b0;
    nxt_nop = 1'b0;
    for (int b = 0; b < NB; b++)
    begin
      nxt_bank[b] = bank_ff[b];
      nxt_bcnt[b] = (bcnt_ff[b] != '0) ? bcnt_ff[b] - `CNT_W'(1) : bcnt_ff[b];
      nxt_apre[b] = apre_ff[b];
      if (bcnt_ff[b] <= `CNT_W'(1))
      begin
        case (bank_ff[b])
          lpddr_pkg::BK_ACTIVATING: nxt_bank[b] = lpddr_pkg::BK_ACTIVE;
          lpddr_pkg::BK_PRECHARGING: nxt_bank[b] = lpddr_pkg::BK_IDLE;
          lpddr_pkg::BK_BUSY: nxt_bank[b] = lpddr_pkg::BK_IDLE;
          lpddr_pkg::BK_WRITE_REC:
          begin
            // auto-precharge write closes the row itself after recovery
            nxt_bank[b] = apre_ff[b] ? lpddr_pkg::BK_PRECHARGING : lpddr_pkg::BK_ACTIVE;
            nxt_bcnt[b] = apre_ff[b] ? RP_C : '0;
            nxt_apre[b] = 1'b0;
          end
          default: nxt_bank[b] = bank_ff[b];
        endcase
      end
    end
    // inputs ignored unless enable held high; pins asleep otherwise
    if (cmd_window && cmd != lpddr_pkg::CMD_DESEL)
    begin
      case (cmd)
        lpddr_pkg::CMD_NOP: nxt_nop = 1'b1;
        lpddr_pkg::CMD_REF, lpddr_pkg::CMD_MRS:
        begin
          if (idle_now)
          begin
            nxt_accepted = 1'b1;
            for (int b = 0; b < NB; b++)
            begin
              nxt_bank[b] = lpddr_pkg::BK_BUSY;
              nxt_bcnt[b] = (cmd == lpddr_pkg::CMD_REF) ? RFC_C : MRD_C;
            end
          end
          else
            nxt_illegal = 1'b1;
        end
        lpddr_pkg::CMD_PRE:
        begin
          if (cmd_pins.addr[`AP_BIT])
          begin
            nxt_nop = 1'b1;
            for (int b = 0; b < NB; b++)
            begin
              if (bank_ff[b] == lpddr_pkg::BK_ACTIVE)
              begin
                nxt_bank[b] = lpddr_pkg::BK_PRECHARGING;
                nxt_bcnt[b] = RP_C;
                nxt_nop = 1'b0;
                nxt_accepted = 1'b1;
              end
            end
          end
          else if (sel_state == lpddr_pkg::BK_ACTIVE)
          begin
            nxt_accepted = 1'b1;
            nxt_bank[cmd_pins.bank] = lpddr_pkg::BK_PRECHARGING;
            nxt_bcnt[cmd_pins.bank] = RP_C;
          end
          else if (sel_state == lpddr_pkg::BK_IDLE ||
                   sel_state == lpddr_pkg::BK_PRECHARGING)
            nxt_nop = 1'b1;
          else
            nxt_illegal = 1'b1;
        end
        lpddr_pkg::CMD_ACT:
        begin
          if (sel_state == lpddr_pkg::BK_IDLE)
          begin
            nxt_accepted = 1'b1;
            nxt_bank[cmd_pins.bank] = lpddr_pkg::BK_ACTIVATING;
            nxt_bcnt[cmd_pins.bank] = RCD_C;
          end
          else
            nxt_illegal = 1'b1;
        end
        lpddr_pkg::CMD_WR:
        begin
          if (sel_state == lpddr_pkg::BK_ACTIVE || sel_state == lpddr_pkg::BK_WRITE_REC)
          begin
            nxt_accepted = 1'b1;
            nxt_bank[cmd_pins.bank] = lpddr_pkg::BK_WRITE_REC;
            nxt_bcnt[cmd_pins.bank] = WR_C;
            nxt_apre[cmd_pins.bank] = wr_autopre;
          end
          else
            nxt_illegal = 1'b1;
        end
        lpddr_pkg::CMD_RD:
        begin
          if (sel_state == lpddr_pkg::BK_ACTIVE)
            nxt_accepted = 1'b1;
          else
            nxt_illegal = 1'b1;
        end
        lpddr_pkg::CMD_BST:
        begin
          if (sel_state == lpddr_pkg::BK_ACTIVE)
            nxt_nop = 1'b1;
          else
            nxt_illegal = 1'b1;
        end
        default: nxt_nop = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int b = 0; b < NB; b++)
      begin
        bank_ff[b] <= lpddr_pkg::BK_IDLE;
        bcnt_ff[b] <= '0;
        apre_ff[b] <= 1'b0;
      end
      cmd_accepted_ff <= 1'b0;
      cmd_illegal_ff <= 1'b0;
      cmd_nop_ff <= 1'b0;
      self_refresh_ff <= 1'b0;
      power_down_ff <= 1'b0;
      all_idle_ff <= 1'b1;
      bank_state_ff <= {NB{lpddr_pkg::BK_IDLE}};
    end
    else
    begin
      for (int b = 0; b < NB; b++)
      begin
        bank_ff[b] <= nxt_bank[b];
        bcnt_ff[b] <= nxt_bcnt[b];
        apre_ff[b] <= nxt_apre[b];
      end
      cmd_accepted_ff <= nxt_accepted;
      cmd_illegal_ff <= nxt_illegal;
      cmd_nop_ff <= nxt_nop;
      self_refresh_ff <= (nxt_pwr == lpddr_pkg::PW_SELF_REF);
      power_down_ff <= (nxt_pwr == lpddr_pkg::PW_POWER_DOWN);
      all_idle_ff <= (nxt_bank[0] == lpddr_pkg::BK_IDLE) && (nxt_bank[1] == lpddr_pkg::BK_IDLE) &&
                     (nxt_bank[2] == lpddr_pkg::BK_IDLE) && (nxt_bank[3] == lpddr_pkg::BK_IDLE);
      bank_state_ff <= {nxt_bank[3], nxt_bank[2], nxt_bank[1], nxt_bank[0]};
    end
  end

  sleep_ignores_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!cke_prev_ff && !cke) |=> !cmd_accepted_ff && !cmd_illegal_ff)
    else $error("command acted on while enable low");
  pd_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pwr_ff == lpddr_pkg::PW_POWER_DOWN && !cke_prev_ff && cke) |=> ##1 !power_down_ff)
    else $error("power-down not left on enable rise");
  sr_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pwr_ff == lpddr_pkg::PW_NORMAL && cke_prev_ff && !cke && idle_now &&
     cmd == lpddr_pkg::CMD_REF) |=> self_refresh_ff)
    else $error("self-refresh not entered");
  ref_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_window && cmd == lpddr_pkg::CMD_REF && !idle_now) |=> cmd_illegal_ff)
    else $error("refresh with busy bank not flagged");
  pre_nop_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_window && cmd == lpddr_pkg::CMD_PRE && !cmd_pins.addr[`AP_BIT] &&
     sel_state == lpddr_pkg::BK_PRECHARGING) |=> cmd_nop_ff && !cmd_illegal_ff)
    else $error("precharge to precharging bank not a nop");
  rd_rec_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_window && cmd == lpddr_pkg::CMD_RD && sel_state == lpddr_pkg::BK_WRITE_REC)
    |=> cmd_illegal_ff)
    else $error("read during write recovery accepted");
  wr_rec_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd_window && cmd == lpddr_pkg::CMD_WR && sel_state == lpddr_pkg::BK_WRITE_REC)
    |=> cmd_accepted_ff)
    else $error("write during write recovery refused");
  wake_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (pwr_ff == lpddr_pkg::PW_WAKE) |=> !cmd_accepted_ff)
    else $error("command taken during exit setup");
endmodule // lpddr_bank_state_cmd_legality

// [lpddr_ctrl_model.sv]
// controller model driving clock enable and the command pins
module lpddr_ctrl_model (
  output logic cke, // clock enable
  output lpddr_pkg::cmd_pins_s cmd_pins, // command, bank and address
  output logic wr_autopre // write carries auto precharge
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cke = 1'b0;
    wr_autopre = 1'b0;
    cmd_pins = '1;
  end
  // one command per call; the caller keeps bank, idle and spacing rules
  task automatic drive(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a,
                       input logic ap, input logic ck);
    cke = ck;
    cmd_pins = {code, b, a};
    wr_autopre = ap;
  endtask
  // deselect; stale lines flipped so nothing rides on leftover values
  task automatic idle_bus(input logic ck);
    cke = ck;
    cmd_pins = {1'b1, ~cmd_pins[17:0]};
    wr_autopre = ~wr_autopre;
  endtask
endmodule // lpddr_ctrl_model

// [lpddr_bank_state_cmd_legality_test.sv]
// self-checking bench for the bank state legality block
module lpddr_bank_state_cmd_legality_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] NOP = 4'h7, BST = 4'h6, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] ACT = 4'h3, PRE = 4'h2, REF = 4'h1, MRS = 4'h0, DES = 4'hF;
  localparam logic [2:0] ACC = 3'h4, ILL = 3'h2, NOPV = 3'h1, NONE = 3'h0;
  logic ref_clk;
  logic rst;
  logic cke;
  lpddr_pkg::cmd_pins_s cmd_pins;
  logic wr_autopre;
  logic acc;
  logic ill;
  logic nop;
  logic sr;
  logic pd;
  logic idle;
  logic [23:0] bst;
  int err_count;
  int checks_done;
  lpddr_ctrl_model i_ctrl (.cke(cke), .cmd_pins(cmd_pins), .wr_autopre(wr_autopre));
  lpddr_bank_state_cmd_legality i_dut (
    .ref_clk(ref_clk), .rst(rst), .cke(cke), .cmd_pins(cmd_pins), .wr_autopre(wr_autopre),
    .cmd_accepted_ff(acc), .cmd_illegal_ff(ill), .cmd_nop_ff(nop), .self_refresh_ff(sr),
    .power_down_ff(pd), .all_idle_ff(idle), .bank_state_ff(bst));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict may land on either of two edges, so both are gathered
  task automatic run(input string what, input logic [3:0] c, input logic [1:0] b,
                     input logic [12:0] a, input logic ap, input logic ck, input logic [2:0] exp);
    logic [2:0] got;
    got = NONE;
    i_ctrl.drive(c, b, a, ap, ck);
    cyc(1);
    i_ctrl.idle_bus(ck);
    got = got | {acc, ill, nop};
    cyc(1);
    got = got | {acc, ill, nop};
    check(what, {21'h0, got}, {21'h0, exp});
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_rows();
    run("act b1", ACT, 2'h1, 13'h0, 1'b0, 1'b1, ACC);
    check("b1 activating", {18'h0, bst[11:6]}, 24'h2);
    run("rd activating", RD, 2'h1, 13'h0, 1'b0, 1'b1, ILL);
    run("act b2", ACT, 2'h2, 13'h0, 1'b0, 1'b1, ACC);
    cyc(4);
    check("b1 active", {18'h0, bst[11:6]}, 24'h4);
    run("pre idle b3", PRE, 2'h3, 13'h0, 1'b0, 1'b1, NOPV);
    run("pre b1", PRE, 2'h1, 13'h0, 1'b0, 1'b1, ACC);
    check("b1 precharging", {18'h0, bst[11:6]}, 24'h8);
    run("act precharging", ACT, 2'h1, 13'h0, 1'b0, 1'b1, ILL);
    run("ref not idle", REF, 2'h0, 13'h0, 1'b0, 1'b1, ILL);
    run("pre all", PRE, 2'h0, 13'h0400, 1'b0, 1'b1, ACC);
    cyc(4);
    check("idle after rp", {23'h0, idle}, 24'h1);
  endtask
  task automatic t_refresh();
    run("ref", REF, 2'h0, 13'h0, 1'b0, 1'b1, ACC);
    check("all busy", bst, 24'h820820);
    run("act refreshing", ACT, 2'h0, 13'h0, 1'b0, 1'b1, ILL);
    run("mrs refreshing", MRS, 2'h0, 13'h0, 1'b0, 1'b1, ILL);
    cyc(12);
    check("idle after rfc", bst, 24'h041041);
    run("mrs", MRS, 2'h0, 13'h0, 1'b0, 1'b1, ACC);
    run("bst mode set", BST, 2'h0, 13'h0, 1'b0, 1'b1, ILL);
    cyc(4);
    run("act b0", ACT, 2'h0, 13'h0, 1'b0, 1'b1, ACC);
    cyc(4);
    // back to back so the second and third land inside write recovery
    i_ctrl.drive(WR, 2'h0, 13'h0, 1'b0, 1'b1);
    cyc(1);
    check("wr b0", {21'h0, acc, ill, nop}, {21'h0, ACC});
    i_ctrl.drive(RD, 2'h0, 13'h0, 1'b0, 1'b1);
    cyc(1);
    check("rd recovering", {21'h0, acc, ill, nop}, {21'h0, ILL});
    i_ctrl.drive(WR, 2'h0, 13'h0, 1'b0, 1'b1);
    cyc(1);
    check("wr recovering", {21'h0, acc, ill, nop}, {21'h0, ACC});
    i_ctrl.idle_bus(1'b1);
    cyc(3);
    run("wr autopre", WR, 2'h0, 13'h0, 1'b1, 1'b1, ACC);
    run("bst autopre", BST, 2'h0, 13'h0, 1'b0, 1'b1, ILL);
    run("pre precharging", PRE, 2'h0, 13'h0, 1'b0, 1'b1, NOPV);
    cyc(12);
    check("idle after autopre", {23'h0, idle}, 24'h1);
  endtask
  task automatic t_power();
    run("bad entry", BST, 2'h0, 13'h0, 1'b0, 1'b0, NONE);
    check("bad entry stays", {22'h0, sr, pd}, 24'h0);
    i_ctrl.idle_bus(1'b1);
    cyc(3);
    run("pd entry", NOP, 2'h0, 13'h0, 1'b0, 1'b0, NONE);
    check("pd set", {23'h0, pd}, 24'h1);
    run("act while pd", ACT, 2'h1, 13'h0, 1'b0, 1'b0, NONE);
    check("pd held", {23'h0, pd}, 24'h1);
    run("act at exit", ACT, 2'h1, 13'h0, 1'b0, 1'b1, NONE);
    check("pd left", {23'h0, pd}, 24'h0);
    cyc(3);
    run("act after pdex", ACT, 2'h0, 13'h0, 1'b0, 1'b1, ACC);
    cyc(4);
    run("pre b0", PRE, 2'h0, 13'h0, 1'b0, 1'b1, ACC);
    cyc(4);
    run("pd deselect", DES, 2'h0, 13'h0, 1'b0, 1'b0, NONE);
    check("pd by deselect", {23'h0, pd}, 24'h1);
    i_ctrl.idle_bus(1'b1);
    cyc(4);
    check("pd left again", {22'h0, sr, pd}, 24'h0);
    run("sr entry", REF, 2'h0, 13'h0, 1'b0, 1'b0, NONE);
    check("sr set", {22'h0, sr, pd}, 24'h2);
    run("act while sr", ACT, 2'h0, 13'h0, 1'b0, 1'b0, NONE);
    check("sr held", {22'h0, sr, pd}, 24'h2);
    i_ctrl.idle_bus(1'b1);
    cyc(2);
    run("act in sr wait", ACT, 2'h0, 13'h0, 1'b0, 1'b1, NONE);
    cyc(20);
    check("sr left", {22'h0, sr, pd}, 24'h0);
    run("act after sr", ACT, 2'h3, 13'h0, 1'b0, 1'b1, ACC);
  endtask
  initial
  begin
    err_count = 0;
    checks_done = 0;
    rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    i_ctrl.idle_bus(1'b1);
    cyc(2);
    check("reset banks", bst, 24'h041041);
    check("reset flags", {20'h0, idle, sr, pd, acc | ill | nop}, 24'h8);
    t_rows();
    t_refresh();
    t_power();
    close_out();
  end
  initial
  begin
    #(20000 * 8);
    err_count++;
    close_out();
  end
endmodule // lpddr_bank_state_cmd_legality_test
